// [logic/aesf_event_flags.sv]
// Upper five event flags of the interrupt summary status register
`default_nettype none
module aesf_event_flags #(
  parameter int unsigned PULSE_CYC = aesf_pkg::PULSE_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic boot_pin_select_i,
  input wire logic active_entry_i,
  input wire logic new_result_i,
  input wire logic rd_axis_i,
  input wire logic rd_temp_i,
  input wire logic rd_vector_magnitude_output_i,
  input wire logic rd_summary_i,
  input wire logic rd_outside_src_i,
  input wire logic rd_inside_src_i,
  input wire logic [1:0] buffer_operating_select_i,
  input wire logic buf_watermark_i,
  input wire logic buf_overflow_i,
  input wire logic buf_gating_error_i,
  input wire logic buf_full_i,
  input wire logic outside_cond_i,
  input wire logic inside_cond_i,
  input wire logic outside_latch_enable_i,
  input wire logic inside_latch_enable_i,
  output logic [7:0] event_summary_o,
  output logic [7:0] summary_read_data_o,
  output logic [1:0] buffer_state_o,
  output logic gating_error_o,
  output logic outside_active_flag_o,
  output logic inside_active_flag_o,
  output logic data_ready_irq_o,
  output logic buffer_irq_o
);

  // ==========================================================
  // State
  logic data_ready_flag;
  logic output_overrun_flag;
  logic buffer_event_flag;
  logic change_outside_flag;
  logic change_inside_flag;
  logic unread;
  logic [aesf_pkg::CNT_W-1:0] pulse_cnt;
  aesf_pkg::aesf_pulse_st_t pulse_state;
  logic data_ready_irq;

  // ==========================================================
  // Next values and decode
  logic buf_on;
  logic buf_trig;
  logic rd_result;
  logic set_drdy;
  logic set_ovf;
  logic wmrk_part;
  logic full_part;
  logic pulse_done;
  logic next_data_ready_flag;
  logic next_output_overrun_flag;
  logic next_buffer_event_flag;
  logic next_change_outside_flag;
  logic next_change_inside_flag;
  logic next_unread;
  logic next_data_ready_irq;
  logic [7:0] summary_flags;
  aesf_pkg::aesf_pulse_st_t next_pulse_state;

  // ==========================================================
  // Counter type and limits
  typedef logic [aesf_pkg::CNT_W-1:0] aesf_cnt_t;
  localparam aesf_cnt_t PULSE_LAST = aesf_cnt_t'(PULSE_CYC - 1);
  localparam aesf_cnt_t CNT_ONE = aesf_cnt_t'(1);
  aesf_cnt_t next_pulse_cnt;

  // ==========================================================
  // Change detection flag update
  function automatic logic latch_next(
    input logic flag,
    input logic cond,
    input logic latch_en,
    input logic rd_src
  );
    logic held;
    held = flag & ~rd_src;
    if (latch_en) begin
      latch_next = cond | held;
    end else begin
      latch_next = cond;
    end
  endfunction

  // ==========================================================
  // Decode
  assign buf_on = (buffer_operating_select_i != aesf_pkg::BUF_MODE_OFF);
  assign buf_trig = (buffer_operating_select_i == aesf_pkg::BUF_MODE_TRIG);
  assign rd_result = rd_axis_i | rd_temp_i | rd_vector_magnitude_output_i;

  // ==========================================================
  // Data ready flag
  assign set_drdy = new_result_i & ~buf_on;
  assign next_data_ready_flag = ~buf_on
    & (set_drdy | (data_ready_flag & ~rd_result));

  // ==========================================================
  // Output overrun flag
  assign next_unread = new_result_i | (unread & ~rd_axis_i);
  assign set_ovf = new_result_i & unread & ~rd_axis_i & ~buf_on;
  assign next_output_overrun_flag = ~buf_on
    & (set_ovf | (output_overrun_flag & ~rd_summary_i));

  // ==========================================================
  // Buffer event flag
  assign wmrk_part = buf_watermark_i & ~buf_trig;
  assign full_part = buf_full_i & buf_trig;
  assign next_buffer_event_flag = buf_on
    & (wmrk_part | buf_overflow_i | buf_gating_error_i | full_part);

  // ==========================================================
  // Change detection flags
  assign next_change_outside_flag = latch_next(
    change_outside_flag,
    outside_cond_i,
    outside_latch_enable_i,
    rd_outside_src_i
  );
  assign next_change_inside_flag = latch_next(
    change_inside_flag,
    inside_cond_i,
    inside_latch_enable_i,
    rd_inside_src_i
  );

  // ==========================================================
  // Data ready pulse timing
  assign pulse_done = (pulse_cnt == PULSE_LAST);

  always_comb begin
    next_pulse_state = pulse_state;
    next_pulse_cnt = pulse_cnt;
    unique case (pulse_state)
      aesf_pkg::AESF_PULSE_IDLE: begin
        next_pulse_cnt = '0;
        if (set_drdy && boot_pin_select_i && !active_entry_i) begin
          next_pulse_state = aesf_pkg::AESF_PULSE_RUN;
        end
      end
      aesf_pkg::AESF_PULSE_RUN: begin
        if (active_entry_i) begin
          next_pulse_state = aesf_pkg::AESF_PULSE_IDLE;
          next_pulse_cnt = '0;
        end else if (pulse_done || !boot_pin_select_i) begin
          next_pulse_state = aesf_pkg::AESF_PULSE_IDLE;
          next_pulse_cnt = '0;
        end else begin
          next_pulse_cnt = pulse_cnt + CNT_ONE;
        end
      end
    endcase
  end

  // ==========================================================
  // Interrupt and summary views
  assign next_data_ready_irq = boot_pin_select_i
    ? (next_pulse_state == aesf_pkg::AESF_PULSE_RUN)
    : next_data_ready_flag;

  always_comb begin
    summary_flags = aesf_pkg::SUMMARY_RST;
    summary_flags[aesf_pkg::DRDY_BIT] = data_ready_flag;
    summary_flags[aesf_pkg::OVF_BIT] = output_overrun_flag;
    summary_flags[aesf_pkg::BUF_BIT] = buffer_event_flag;
    summary_flags[aesf_pkg::OT_BIT] = change_outside_flag;
    summary_flags[aesf_pkg::WT_BIT] = change_inside_flag;
  end

  assign event_summary_o = summary_flags;
  assign outside_active_flag_o = change_outside_flag;
  assign inside_active_flag_o = change_inside_flag;
  assign data_ready_irq_o = data_ready_irq;

  // ==========================================================
  // Flag registers
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      data_ready_flag <= 1'h0;
      output_overrun_flag <= 1'h0;
      unread <= 1'h0;
    end else begin
      data_ready_flag <= next_data_ready_flag;
      output_overrun_flag <= next_output_overrun_flag;
      unread <= next_unread;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      buffer_event_flag <= 1'h0;
      change_outside_flag <= 1'h0;
      change_inside_flag <= 1'h0;
    end else begin
      buffer_event_flag <= next_buffer_event_flag;
      change_outside_flag <= next_change_outside_flag;
      change_inside_flag <= next_change_inside_flag;
    end
  end

  // ==========================================================
  // Pulse registers
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      pulse_state <= aesf_pkg::AESF_PULSE_IDLE;
      pulse_cnt <= '0;
      data_ready_irq <= 1'h0;
    end else begin
      pulse_state <= next_pulse_state;
      pulse_cnt <= next_pulse_cnt;
      data_ready_irq <= next_data_ready_irq;
    end
  end

  // ==========================================================
  // Host visible registers
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      summary_read_data_o <= aesf_pkg::SUMMARY_RST;
    end else if (rd_summary_i) begin
      summary_read_data_o <= summary_flags;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      buffer_state_o <= 2'h0;
      gating_error_o <= 1'h0;
      buffer_irq_o <= 1'h0;
    end else begin
      buffer_state_o <= {buf_overflow_i, buf_watermark_i};
      gating_error_o <= buf_gating_error_i;
      buffer_irq_o <= next_buffer_event_flag;
    end
  end

  // ==========================================================
  // Assertions
  default clocking aesf_cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);

  a_drdy_set: assert property (
    (new_result_i && !buf_on) |=> data_ready_flag
  ) else $error("data ready flag not set on a new result");

  a_drdy_read_clear: assert property (
    (rd_result && !new_result_i) |=> !data_ready_flag
  ) else $error("data ready flag not cleared by a result read");

  a_drdy_buffer_low: assert property (
    buf_on |=> !data_ready_flag
  ) else $error("data ready flag set while buffer enabled");

  a_level_irq_track: assert property (
    !boot_pin_select_i |=> (data_ready_irq_o == data_ready_flag)
  ) else $error("level interrupt differs from data ready flag");

  a_pulse_count_bound: assert property (
    pulse_cnt <= PULSE_LAST
  ) else $error("pulse counter beyond pulse length");

  a_pulse_start: assert property (
    (boot_pin_select_i && set_drdy && !active_entry_i
      && pulse_state == aesf_pkg::AESF_PULSE_IDLE) |=> data_ready_irq_o
  ) else $error("data ready pulse did not start");

  a_pulse_active_end: assert property (
    (boot_pin_select_i && active_entry_i) |=> !data_ready_irq_o
  ) else $error("data ready pulse not ended by active entry");

  a_ovf_set: assert property (
    (new_result_i && unread && !rd_axis_i && !buf_on) |=> output_overrun_flag
  ) else $error("overrun flag not set on unread results");

  a_ovf_axis_read: assert property (
    (rd_axis_i && !output_overrun_flag) |=> !output_overrun_flag
  ) else $error("overrun raised although an axis output was read");

  a_ovf_read_clear: assert property (
    (rd_summary_i && !new_result_i) |=> !output_overrun_flag
  ) else $error("overrun flag not cleared by a summary read");

  a_ovf_buffer_low: assert property (
    buf_on |=> !output_overrun_flag
  ) else $error("overrun flag set while buffer enabled");

  a_buf_flag_or: assert property (
    (buf_on && (buf_overflow_i || buf_gating_error_i)) |=> buffer_event_flag
  ) else $error("buffer event flag missing for an active condition");

  a_buf_state_view: assert property (
    buffer_state_o[0] == $past(buf_watermark_i)
  ) else $error("buffer state does not show the watermark");

  a_buf_off_low: assert property (
    !buf_on |=> !buffer_event_flag
  ) else $error("buffer event flag set while buffer disabled");

  a_trig_wmrk_quiet: assert property (
    (buf_trig && !buf_overflow_i && !buf_gating_error_i && !buf_full_i) |=> !buffer_event_flag
  ) else $error("watermark raised the flag in triggered mode");

  a_trig_full_set: assert property (
    (buf_trig && buf_full_i) |=> buffer_event_flag
  ) else $error("full buffer did not set the flag in triggered mode");

  a_outside_set: assert property (
    outside_cond_i |=> outside_active_flag_o
  ) else $error("outside flag not set by its condition");

  a_outside_follow: assert property (
    !outside_latch_enable_i |=> (change_outside_flag == $past(outside_cond_i))
  ) else $error("unlatched outside flag does not follow its condition");

  a_outside_hold: assert property (
    (outside_latch_enable_i && change_outside_flag && !rd_outside_src_i) |=> change_outside_flag
  ) else $error("latched outside flag lost without a source read");

  a_inside_set: assert property (
    inside_cond_i |=> inside_active_flag_o
  ) else $error("inside flag not set by its condition");

  a_inside_follow: assert property (
    !inside_latch_enable_i |=> (change_inside_flag == $past(inside_cond_i))
  ) else $error("unlatched inside flag does not follow its condition");

  a_read_capture: assert property (
    rd_summary_i |=> (summary_read_data_o == $past(event_summary_o))
  ) else $error("read data is not the flags before clearing");

  // ==========================================================
  // Coverage
  c_pulse_full: cover property (pulse_state == aesf_pkg::AESF_PULSE_RUN && pulse_done);

  c_pulse_early: cover property (pulse_state == aesf_pkg::AESF_PULSE_RUN && active_entry_i);

  c_overrun: cover property (new_result_i && unread && !buf_on);

  c_trig_full: cover property (buf_trig && buf_full_i);
endmodule
`default_nettype wire

// [logic/aesf_pkg.sv]
// Constants and types for the accelerometer event summary flags
// Behaviour
// - Set data ready flag, bit 7, when a fresh result set arrives.
// - Clear data ready flag on any temperature, magnitude or axis output read.
// - Hold data ready flag low while the output buffer is enabled.
// - Boot pin low: result read clears the flag and its level interrupt.
// - Boot pin high: result read clears flag; interrupt is a self-ending pulse.
// - Entering active mode ends a running data ready pulse early.
// - Set overrun flag, bit 6, when new results replace an unread set.
// - No overrun if an axis output was read before the next set.
// - Every read of the summary register clears the overrun flag.
// - Hold overrun flag low while the output buffer is enabled.
// - Buffer event flag, bit 5, is watermark OR overflow OR gating error.
// - Expose watermark, overflow and gating error details to the host.
// - Buffer event flag stays low while the buffer is disabled.
// - Triggered mode: watermark still shows but drives no summary flag.
// - Triggered mode: full buffer sets buffer event flag and its interrupt.
// - Bit 4 mirrors the outside active flag of the outside source register.
// - Outside flag latched until source read, else follows the condition.
// - Bit 3 mirrors the inside active flag of the inside source register.
// - Inside flag latched until source read, else follows the condition.
// - Summary register sits at address 00h and is read only.
`default_nettype none
package aesf_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_FREQ_MHZ = 125;
  localparam int unsigned PULSE_TIME_US = 5000;
  localparam int unsigned PULSE_CYCLES = PULSE_TIME_US * CLK_FREQ_MHZ;
  localparam int CNT_W = 20;
  // ==========================================================
  // Register map and fields
  localparam logic [7:0] SUMMARY_ADDR = 8'h00;
  localparam logic [7:0] SUMMARY_RST = 8'h00;
  localparam int DRDY_BIT = 7;
  localparam int OVF_BIT = 6;
  localparam int BUF_BIT = 5;
  localparam int OT_BIT = 4;
  localparam int WT_BIT = 3;
  // ==========================================================
  // Buffer modes
  localparam logic [1:0] BUF_MODE_OFF = 2'h0;
  localparam logic [1:0] BUF_MODE_TRIG = 2'h3;
  // ==========================================================
  // Data ready interrupt pulse states
  typedef enum logic {AESF_PULSE_IDLE, AESF_PULSE_RUN} aesf_pulse_st_t;
endpackage
`default_nettype wire

// [tb/aesf_host_model.sv]
// Host model that turns a request into an axis read strobe one cycle later
`default_nettype none
module aesf_host_model (
  input wire logic clk_sys_i,
  input wire logic req_i,
  output logic rd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clk_sys_i) rd_o <= req_i;
endmodule
`default_nettype wire

// [tb/aesf_event_flags_bench.sv]
// Bench for the event summary flags
`default_nettype none
module aesf_event_flags_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 0, reset_n_i = 0, ra;
  logic [18:0] s = '0;
  logic [7:0] es;
  logic [7:0] rdat;
  logic [1:0] bst;
  logic ge, oa, ia, dirq, birq;
  int n_fail = 0, cmp_count = 0;
  `define CHK(n,e,v) begin cmp_count++; if ((v) !== (e)) begin n_fail++; \
    $display("MISMATCH %s exp %h got %h", n, e, v); end end
  always #4 clk_sys_i = ~clk_sys_i;
  aesf_host_model u_host (.clk_sys_i(clk_sys_i), .req_i(s[18]), .rd_o(ra));
  aesf_event_flags #(.PULSE_CYC(4)) u_dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .boot_pin_select_i(s[0]), .active_entry_i(s[1]), .new_result_i(s[2]), .rd_axis_i(ra),
    .rd_temp_i(s[3]), .rd_vector_magnitude_output_i(s[4]), .rd_summary_i(s[5]), .rd_outside_src_i(s[6]),
    .rd_inside_src_i(s[7]), .buffer_operating_select_i(s[9:8]), .buf_watermark_i(s[10]),
    .buf_overflow_i(s[11]), .buf_gating_error_i(s[12]), .buf_full_i(s[13]),
    .outside_cond_i(s[14]), .inside_cond_i(s[15]), .outside_latch_enable_i(s[16]),
    .inside_latch_enable_i(s[17]), .event_summary_o(es), .summary_read_data_o(rdat),
    .buffer_state_o(bst), .gating_error_o(ge), .outside_active_flag_o(oa),
    .inside_active_flag_o(ia), .data_ready_irq_o(dirq), .buffer_irq_o(birq));
  task automatic pulse(input int b);
    @(posedge clk_sys_i); #1 s[b] = 1; @(posedge clk_sys_i); #1 s[b] = 0;
    repeat (3) @(posedge clk_sys_i); #1;
  endtask
  task complete_run;
    $display("n_fail %0d cmp_count %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin #20000 n_fail++; complete_run; end
  initial begin
    repeat (20) @(posedge clk_sys_i); #1 reset_n_i = 1;
    pulse(2); `CHK("drdy", 1'h1, es[7])
    pulse(18); `CHK("drdy rd", 1'h0, es[7])
    pulse(2); pulse(2); `CHK("ovf", 1'h1, es[6])
    pulse(5); `CHK("ovf rd", 1'h0, es[6])
    `CHK("rdat", 8'hC0, rdat)
    s[16] = 1; s[14] = 1; pulse(15); s[14] = 0; pulse(15); `CHK("ot", 1'h1, es[4])
    `CHK("oa", 1'h1, oa)
    pulse(6); `CHK("ot rd", 1'h0, es[4])
    s[10] = 1; pulse(3); `CHK("buf off", 1'h0, es[5])
    `CHK("bst", 2'h1, bst)
    s[8] = 1; pulse(4); `CHK("buf", 1'h1, es[5])
    pulse(2); `CHK("drdy buf", 1'h0, es[7])
    `CHK("ovf buf", 1'h0, es[6])
    s[10] = 0; s[12] = 1; pulse(3); `CHK("gate", 1'h1, ge)
    `CHK("buf gate", 1'h1, es[5])
    s[12] = 0; s[9] = 1; s[10] = 1; pulse(3); `CHK("trig wm", 1'h0, es[5])
    `CHK("trig bst", 2'h1, bst)
    s[13] = 1; pulse(3); `CHK("trig full", 1'h1, es[5])
    `CHK("trig irq", 1'h1, birq)
    s[13] = 0; s[10] = 0; s[9:8] = 2'h0; pulse(3); `CHK("buf off2", 1'h0, es[5])
    pulse(18); pulse(2); pulse(18); pulse(2); `CHK("no ovf", 1'h0, es[6])
    `CHK("lvl irq", 1'h1, dirq)
    pulse(3); `CHK("lvl irq rd", 1'h0, dirq)
    s[0] = 1; pulse(2); `CHK("pulse on", 1'h1, dirq)
    `CHK("drdy boot", 1'h1, es[7])
    repeat (2) @(posedge clk_sys_i); #1 `CHK("pulse end", 1'h0, dirq)
    @(posedge clk_sys_i); #1 s[2] = 1; @(posedge clk_sys_i); #1 s[2] = 0; s[1] = 1;
    @(posedge clk_sys_i); #1 s[1] = 0; `CHK("pulse cut", 1'h0, dirq)
    s[17] = 1; pulse(15); `CHK("wt", 1'h1, es[3])
    `CHK("ia", 1'h1, ia)
    pulse(7); `CHK("wt rd", 1'h0, es[3])
    complete_run;
  end
endmodule
`default_nettype wire
